// ==== lio_pkg.sv ====
// constants, field layouts and carrier types of the local i/o bus controller with dma
package lio_pkg;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_NS = 4;
    localparam int FAST_STROBE_NS = 200;
    localparam int SLOW_STROBE_NS = 800;
    localparam int ROM_STROBE_NS = 120;
    localparam int UDMA0_NS = 120;
    localparam int UDMA1_NS = 80;
    localparam int UDMA2_NS = 60;
    localparam logic [7:0] FAST_STROBE_CYC = 8'((FAST_STROBE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] SLOW_STROBE_CYC = 8'((SLOW_STROBE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] ROM_STROBE_CYC = 8'((ROM_STROBE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] UDMA0_CYC = 8'((UDMA0_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] UDMA1_CYC = 8'((UDMA1_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] UDMA2_CYC = 8'((UDMA2_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] SETUP_CYC = 8'h02;

    // ****************************************
    // register map and fields
    // ****************************************
    localparam logic [7:0] CFG_OFS = 8'h00;
    localparam logic [7:0] DMA_CTRL_OFS = 8'h04;
    localparam logic [7:0] DMA_REQ_OFS = 8'h08;
    localparam logic [7:0] DMA_ADDR_OFS = 8'h0c;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    localparam logic [31:0] DMA_ADDR_RESET = 32'h0000_0000;
    localparam int CFG_BUF_BIT = 0;
    localparam int CFG_FAST_BIT = 1;
    localparam int CFG_WIDE_BIT = 2;
    localparam int CFG_SEL_STRIDE = 3;
    localparam int CFG_SWAP_BIT = 14;
    localparam int CFG_UDMA_BIT = 15;
    localparam int CFG_RATE_LSB = 16;
    localparam int CTRL_START_BIT = 31;
    localparam int CTRL_RESET_BIT = 30;
    localparam int REQ_DIR_BIT = 16;

    // wishbone byte address: bit 24 selects the local bus space, 23-21 the region
    localparam int ADR_W = 25;
    localparam int LOCAL_SPACE_BIT = 24;
    localparam int REGION_LSB = 21;
    localparam logic [2:0] ROM_REGION = 3'h4;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [2:0] {
        LIO_IDLE = 3'b000,
        LIO_FETCH = 3'b001,
        LIO_SETUP = 3'b010,
        LIO_STROBE = 3'b011,
        LIO_HOLD = 3'b100,
        LIO_DONE = 3'b101,
        LIO_STORE = 3'b110
    } lio_state_t;

    typedef struct packed {
        logic dir;
        logic [15:0] count;
        logic [31:0] addr;
    } lio_dma_entry_t;

    typedef struct packed {
        logic req;
        logic we;
        logic [31:0] addr;
        logic [15:0] wdata;
    } lio_mem_req_t;

    typedef struct packed {
        logic [3:0] sel_n;
        logic rom_n;
        logic dack_n;
        logic rd_n;
        logic wr_n;
        logic buf_en_n;
        logic buf_dir;
        logic [4:0] addr_low;
        logic mdb_oe;
        logic [31:0] mdb;
        logic d_oe;
        logic [15:0] dout;
    } lio_pins_t;

    localparam lio_pins_t PINS_IDLE = '{sel_n: 4'hf, rom_n: 1'b1, dack_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
        buf_en_n: 1'b1, buf_dir: 1'b0, addr_low: 5'h00, mdb_oe: 1'b0, mdb: 32'h0, d_oe: 1'b0, dout: 16'h0};
endpackage

// ==== lio_top.sv ====
// local i/o bus controller: wishbone slave, strobe sequencer and two-entry half-word dma
//
// Added by the designer: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/10ps
module lio_top
    import lio_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic [3:0] io_select_n,
    output logic rom_select_n,
    output logic io_read_strobe_n,
    output logic io_write_strobe_n,
    input wire logic io_wait_release,
    output logic buffer_direction,
    output logic buffer_enable_n,
    output logic [4:0] local_addr_low,
    input wire logic [15:0] local_data_bus_in,
    output logic [15:0] local_data_bus_out,
    output logic local_data_bus_oe,
    output logic [31:0] memory_data_bus_out,
    output logic memory_data_bus_oe,
    input wire logic dma_request,
    output logic dma_ack_n,
    output lio_mem_req_t mem_cmd,
    input wire logic mem_ack,
    input wire logic [15:0] mem_rdata,
    output logic dma_idle_level,
    output logic dma_accept_ready
);
    // ****************************************
    // pin synchronisers
    // ****************************************
    logic ready_s1, ready_q, dmarq_s1, dmarq_q;
    logic [15:0] data_s1, data_q;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ready_s1 <= 1'b1;
            ready_q <= 1'b1;
            dmarq_s1 <= 1'b0;
            dmarq_q <= 1'b0;
            data_s1 <= 16'h0000;
            data_q <= 16'h0000;
        end else begin
            ready_s1 <= io_wait_release;
            ready_q <= ready_s1;
            dmarq_s1 <= dma_request;
            dmarq_q <= dmarq_s1;
            data_s1 <= local_data_bus_in;
            data_q <= data_s1;
        end
    end

    // ****************************************
    // registers and state
    // ****************************************
    logic [31:0] cfg_reg, dma_addr_reg;
    logic dma_reset_reg;
    logic [15:0] req_count_reg;
    logic req_dir_reg;
    lio_dma_entry_t q_reg [2];
    lio_dma_entry_t q_next [2];
    logic [1:0] q_count_reg, q_count_next;
    lio_state_t state_reg;
    logic [7:0] cnt_reg, width_reg;
    logic is_dma_reg, is_rom_reg, beat_reg, wr_cyc_reg;
    logic [15:0] beat0_reg;
    lio_pins_t pins_reg, cpu_pins, dma_pins;

    wire [2:0] region = wb_adr_i[REGION_LSB +: 3];
    wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire local_hit = wb_adr_i[LOCAL_SPACE_BIT] && (region[2] == 1'b0 || (region == ROM_REGION && !wb_we_i));
    wire reg_req = bus_req && !local_hit;
    wire [7:0] reg_ofs = wb_adr_i[7:0];
    wire ctrl_wr = reg_req && wb_we_i && reg_ofs == DMA_CTRL_OFS && wb_sel_i[3];
    wire [1:0] sel_idx = region[1:0];
    wire cfg_buf = cfg_reg[CFG_SEL_STRIDE * sel_idx + CFG_BUF_BIT];
    wire cfg_fast = cfg_reg[CFG_SEL_STRIDE * sel_idx + CFG_FAST_BIT];
    wire cfg_wide = cfg_reg[CFG_SEL_STRIDE * sel_idx + CFG_WIDE_BIT];
    // submission needs the engine already out of reset and a free slot
    wire push = ctrl_wr && wb_dat_i[CTRL_START_BIT] && !wb_dat_i[CTRL_RESET_BIT] && !dma_reset_reg
        && q_count_reg != 2'd2;
    wire dma_go = !dma_reset_reg && q_count_reg != 2'd0 && q_reg[0].count != 16'h0 && dmarq_q;
    wire cpu_go = bus_req && local_hit;
    wire beat_done = (state_reg == LIO_DONE && is_dma_reg && q_reg[0].dir)
        || (state_reg == LIO_STORE && mem_ack);
    wire pop = q_count_reg != 2'd0 && q_reg[0].count == 16'h0 && state_reg == LIO_IDLE;
    wire [15:0] rd_swapped = cfg_reg[CFG_SWAP_BIT] ? {data_q[7:0], data_q[15:8]} : data_q;
    wire [31:0] cpu_addr = {{(32 - ADR_W){1'b0}}, wb_adr_i};

    function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = wd[8*b +: 8];
            end
        end
        return r;
    endfunction

    // ****************************************
    // wishbone register slave
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cfg_reg <= CFG_RESET;
            dma_addr_reg <= DMA_ADDR_RESET;
            dma_reset_reg <= 1'b1;
            req_count_reg <= 16'h0000;
            req_dir_reg <= 1'b0;
        end else if (reg_req && wb_we_i) begin
            case (reg_ofs)
                CFG_OFS: cfg_reg <= merge_bytes(cfg_reg, wb_dat_i, wb_sel_i);
                DMA_ADDR_OFS: dma_addr_reg <= merge_bytes(dma_addr_reg, wb_dat_i, wb_sel_i);
                DMA_REQ_OFS: begin
                    req_count_reg <= wb_dat_i[15:0];
                    req_dir_reg <= wb_dat_i[REQ_DIR_BIT];
                end
                DMA_CTRL_OFS: begin
                    if (wb_sel_i[3]) begin
                        dma_reset_reg <= wb_dat_i[CTRL_RESET_BIT];
                    end
                end
                default: ;
            endcase
        end
    end

    // reads of unmapped offsets answer with zero; local cycles answer from the sequencer
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= reg_req || (state_reg == LIO_DONE && !is_dma_reg && !(is_rom_reg && !beat_reg));
            if (reg_req && !wb_we_i) begin
                case (reg_ofs)
                    CFG_OFS: wb_dat_o <= cfg_reg;
                    DMA_ADDR_OFS: wb_dat_o <= dma_addr_reg;
                    DMA_CTRL_OFS: wb_dat_o <= {q_count_reg == 2'd0, dma_reset_reg, 13'h0000,
                        q_reg[0].dir, q_reg[0].count};
                    default: wb_dat_o <= 32'h0;
                endcase
            end else if (state_reg == LIO_DONE && !is_dma_reg) begin
                wb_dat_o <= is_rom_reg ? {data_q, beat0_reg} : {16'h0000, data_q};
            end
        end
    end

    // ****************************************
    // dma queue
    // ****************************************
    always_comb begin
        q_next = q_reg;
        q_count_next = q_count_reg;
        if (beat_done) begin
            q_next[0].count = q_reg[0].count - 16'h0001;
            q_next[0].addr = q_reg[0].addr + 32'h2;
        end
        if (pop) begin
            q_next[0] = q_reg[1];
            q_count_next = q_count_reg - 2'd1;
        end
        if (push) begin
            q_next[q_count_next[0]] = '{dir: req_dir_reg, count: req_count_reg, addr: dma_addr_reg};
            q_count_next = q_count_next + 2'd1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst || dma_reset_reg) begin
            q_reg[0] <= '0;
            q_reg[1] <= '0;
            q_count_reg <= 2'd0;
        end else begin
            q_reg <= q_next;
            q_count_reg <= q_count_next;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dma_idle_level <= 1'b1;
            dma_accept_ready <= 1'b0;
        end else begin
            dma_idle_level <= q_count_next == 2'd0 || dma_reset_reg;
            dma_accept_ready <= q_count_next != 2'd2 && !dma_reset_reg;
        end
    end

    // ****************************************
    // strobe sequencer
    // ****************************************
    always_comb begin
        cpu_pins = PINS_IDLE;
        if (region == ROM_REGION) begin
            cpu_pins.rom_n = 1'b0;
            cpu_pins.addr_low = {wb_adr_i[5:2], 1'b0};
            cpu_pins.mdb_oe = 1'b1;
            cpu_pins.mdb = cpu_addr;
        end else begin
            cpu_pins.sel_n[sel_idx] = 1'b0;
            cpu_pins.addr_low = wb_adr_i[6:2];
            cpu_pins.mdb_oe = cfg_wide;
            cpu_pins.mdb = cpu_addr;
            cpu_pins.buf_en_n = !cfg_buf;
            cpu_pins.buf_dir = wb_we_i;
            cpu_pins.d_oe = wb_we_i;
            cpu_pins.dout = wb_dat_i[15:0];
        end
        dma_pins = PINS_IDLE;
        dma_pins.dack_n = 1'b0;
        dma_pins.d_oe = q_reg[0].dir;
        dma_pins.dout = mem_rdata;
    end

    logic [7:0] cpu_width, dma_width;
    always_comb begin
        if (region == ROM_REGION) begin
            cpu_width = ROM_STROBE_CYC;
        end else begin
            cpu_width = cfg_fast ? FAST_STROBE_CYC : SLOW_STROBE_CYC;
        end
        if (!cfg_reg[CFG_UDMA_BIT]) begin
            dma_width = FAST_STROBE_CYC;
        end else begin
            case (cfg_reg[CFG_RATE_LSB +: 5])
                5'h01: dma_width = UDMA1_CYC;
                5'h02: dma_width = UDMA2_CYC;
                default: dma_width = UDMA0_CYC;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_reg <= LIO_IDLE;
            pins_reg <= PINS_IDLE;
            cnt_reg <= 8'h00;
            width_reg <= FAST_STROBE_CYC;
            is_dma_reg <= 1'b0;
            is_rom_reg <= 1'b0;
            beat_reg <= 1'b0;
            wr_cyc_reg <= 1'b0;
            beat0_reg <= 16'h0000;
            mem_cmd <= '0;
        end else if (is_dma_reg && dma_reset_reg && state_reg != LIO_IDLE) begin
            // a dma reset abandons the beat in flight and releases the bus at once
            state_reg <= LIO_IDLE;
            pins_reg <= PINS_IDLE;
            mem_cmd <= '0;
        end else begin
            case (state_reg)
                LIO_IDLE: begin
                    cnt_reg <= 8'h00;
                    beat_reg <= 1'b0;
                    if (dma_go) begin
                        is_dma_reg <= 1'b1;
                        is_rom_reg <= 1'b0;
                        wr_cyc_reg <= q_reg[0].dir;
                        width_reg <= dma_width;
                        if (q_reg[0].dir) begin
                            mem_cmd <= '{req: 1'b1, we: 1'b0, addr: q_reg[0].addr, wdata: 16'h0000};
                            state_reg <= LIO_FETCH;
                        end else begin
                            pins_reg <= dma_pins;
                            state_reg <= LIO_SETUP;
                        end
                    end else if (cpu_go) begin
                        is_dma_reg <= 1'b0;
                        is_rom_reg <= region == ROM_REGION;
                        wr_cyc_reg <= wb_we_i;
                        width_reg <= cpu_width;
                        pins_reg <= cpu_pins;
                        state_reg <= LIO_SETUP;
                    end
                end
                LIO_FETCH: begin
                    if (mem_ack) begin
                        mem_cmd <= '0;
                        pins_reg <= dma_pins;
                        state_reg <= LIO_SETUP;
                    end
                end
                LIO_SETUP: begin
                    if (cnt_reg == SETUP_CYC - 8'h01) begin
                        cnt_reg <= 8'h01;
                        pins_reg.rd_n <= wr_cyc_reg;
                        pins_reg.wr_n <= !wr_cyc_reg;
                        state_reg <= LIO_STROBE;
                    end else begin
                        cnt_reg <= cnt_reg + 8'h01;
                    end
                end
                LIO_STROBE: begin
                    // ready seen low holds the strobe; release only once width is met and ready is high
                    if (cnt_reg >= width_reg && ready_q) begin
                        pins_reg.rd_n <= 1'b1;
                        pins_reg.wr_n <= 1'b1;
                        state_reg <= LIO_HOLD;
                    end else if (cnt_reg != 8'hff) begin
                        cnt_reg <= cnt_reg + 8'h01;
                    end
                end
                LIO_HOLD: begin
                    pins_reg <= PINS_IDLE;
                    state_reg <= LIO_DONE;
                end
                LIO_DONE: begin
                    cnt_reg <= 8'h00;
                    if (is_dma_reg && !wr_cyc_reg) begin
                        mem_cmd <= '{req: 1'b1, we: 1'b1, addr: q_reg[0].addr, wdata: rd_swapped};
                        state_reg <= LIO_STORE;
                    end else if (is_rom_reg && !beat_reg) begin
                        // second half-word of a rom word: next low address, fresh setup
                        beat_reg <= 1'b1;
                        beat0_reg <= data_q;
                        pins_reg <= cpu_pins;
                        pins_reg.addr_low <= cpu_pins.addr_low + 5'h01;
                        state_reg <= LIO_SETUP;
                    end else begin
                        state_reg <= LIO_IDLE;
                    end
                end
                LIO_STORE: begin
                    if (mem_ack) begin
                        mem_cmd <= '0;
                        state_reg <= LIO_IDLE;
                    end
                end
                default: state_reg <= LIO_IDLE;
            endcase
        end
    end

    assign io_select_n = pins_reg.sel_n;
    assign rom_select_n = pins_reg.rom_n;
    assign dma_ack_n = pins_reg.dack_n;
    assign io_read_strobe_n = pins_reg.rd_n;
    assign io_write_strobe_n = pins_reg.wr_n;
    assign buffer_enable_n = pins_reg.buf_en_n;
    assign buffer_direction = pins_reg.buf_dir;
    assign local_addr_low = pins_reg.addr_low;
    assign memory_data_bus_oe = pins_reg.mdb_oe;
    assign memory_data_bus_out = pins_reg.mdb;
    assign local_data_bus_oe = pins_reg.d_oe;
    assign local_data_bus_out = pins_reg.dout;

    // ****************************************
    // checks
    // ****************************************
    wire any_sel = pins_reg.sel_n != 4'hf || !pins_reg.rom_n || !pins_reg.dack_n;
    wire strobe_on = !pins_reg.rd_n || !pins_reg.wr_n;
    logic [7:0] strobe_len;
    always_ff @(posedge ref_clk) begin
        if (rst || !strobe_on) begin
            strobe_len <= 8'h00;
        end else if (strobe_len != 8'hff) begin
            strobe_len <= strobe_len + 8'h01;
        end
    end

    setup_lead_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(strobe_on) |-> $past(any_sel, 1) && $past(any_sel, 2))
        else $error("strobe asserted without two cycles of select setup");
    hold_after_a: assert property (@(posedge ref_clk) disable iff (rst || dma_reset_reg)
        $fell(strobe_on) |-> any_sel ##1 !any_sel)
        else $error("select not held exactly one cycle after strobe");
    strobe_width_a: assert property (@(posedge ref_clk) disable iff (rst || dma_reset_reg)
        $fell(strobe_on) |-> strobe_len >= width_reg)
        else $error("strobe released before its width");
    rom_width_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(strobe_on) && !pins_reg.rom_n |-> width_reg == ROM_STROBE_CYC)
        else $error("rom strobe width wrong");
    ready_stretch_a: assert property (@(posedge ref_clk) disable iff (rst || dma_reset_reg)
        state_reg == LIO_STROBE && !ready_q |=> strobe_on)
        else $error("strobe ended while ready low");
    write_data_a: assert property (@(posedge ref_clk) disable iff (rst)
        !pins_reg.wr_n |-> pins_reg.d_oe)
        else $error("write strobe without driven data");
    wide_addr_a: assert property (@(posedge ref_clk) disable iff (rst)
        !pins_reg.rom_n |-> pins_reg.mdb_oe)
        else $error("rom cycle without address on memory data bus");
    accept_full_a: assert property (@(posedge ref_clk) disable iff (rst)
        q_count_reg == 2'd2 |-> !dma_accept_ready)
        else $error("accept-ready while queue full");
    reset_flush_a: assert property (@(posedge ref_clk) disable iff (rst)
        dma_reset_reg |=> q_count_reg == 2'd0 && dma_idle_level)
        else $error("dma reset left entries queued");
    dma_wait_a: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(pins_reg.dack_n) |-> $past(dmarq_q) || $past(mem_cmd.req))
        else $error("dma beat began without request");
endmodule

// ==== lio_partner.sv ====
// peripheral, disk and sdram stand-in on the far side of the local i/o controller
`timescale 1ns/10ps
module lio_partner
    import lio_pkg::*;
(
    input wire logic ref_clk,
    input wire logic [3:0] io_select_n,
    input wire logic io_read_strobe_n,
    input wire logic io_write_strobe_n,
    input wire logic dma_ack_n,
    input wire logic [15:0] local_data_bus_out,
    output logic [15:0] local_data_bus_in,
    input wire lio_mem_req_t mem_cmd,
    output logic mem_ack,
    output logic [15:0] mem_rdata,
    input wire logic dreq_en,
    output logic dma_request,
    output logic io_wait_release
);
    // ****************************************
    // peripheral and sdram
    // ****************************************
    logic [15:0] last_wr = 16'h0000;
    logic hit;
    assign hit = ~io_select_n[0] | ~dma_ack_n;
    // reads are held off by ready for a fixed stretch that outlasts the fast strobe width
    logic [7:0] stall;
    assign io_wait_release = !(hit & ~io_read_strobe_n & (stall < 8'd60));
    always_ff @(posedge ref_clk) begin
        stall <= (hit & ~io_read_strobe_n) ? stall + 8'h01 : 8'h00;
    end
    assign dma_request = dreq_en;
    // released bus shows the inverse so a late sample cannot pass by luck
    assign local_data_bus_in = (hit & ~io_read_strobe_n) ? last_wr : ~last_wr;
    always @(posedge io_write_strobe_n) begin
        if (hit) begin
            last_wr <= local_data_bus_out;
        end
    end
    always_ff @(posedge ref_clk) begin
        mem_ack <= mem_cmd.req & ~mem_ack;
        mem_rdata <= mem_cmd.addr[15:0] ^ 16'hbeef;
    end
endmodule

// ==== lio_top_test.sv ====
// self-checking bench of the local i/o controller: registers, i/o cycles and dma
`timescale 1ns/10ps
module lio_top_test;
    import lio_pkg::*;
    logic ref_clk = 1'b0, rst = 1'b1, cyc = 1'b0, we = 1'b0, dreq_en = 1'b0;
    logic [ADR_W-1:0] adr = '0;
    logic [31:0] dat = 32'h0, q, rdo;
    logic ack, wrel, dreq, mack, dack_n, idle, rdy;
    logic [3:0] sel_n;
    logic rd_n, wr_n;
    logic [15:0] din, dout, mrd;
    logic bdir, ben, doe, moe;
    logic [4:0] la;
    logic [8:0] pin_seen = 9'h000;
    int rd_low = 0;
    lio_mem_req_t mcmd;
    int mismatches = 0, check_count = 0, cyc_cnt = 0;
    lio_top dut_u (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdo), .wb_ack_o(ack), .io_select_n(sel_n), .rom_select_n(),
        .io_read_strobe_n(rd_n), .io_write_strobe_n(wr_n), .io_wait_release(wrel), .buffer_direction(bdir),
        .buffer_enable_n(ben), .local_addr_low(la), .local_data_bus_in(din), .local_data_bus_out(dout),
        .local_data_bus_oe(doe), .memory_data_bus_out(), .memory_data_bus_oe(moe), .dma_request(dreq),
        .dma_ack_n(dack_n), .mem_cmd(mcmd), .mem_ack(mack), .mem_rdata(mrd), .dma_idle_level(idle),
        .dma_accept_ready(rdy));
    lio_partner p_u (.ref_clk(ref_clk), .io_select_n(sel_n), .io_read_strobe_n(rd_n), .io_write_strobe_n(wr_n),
        .dma_ack_n(dack_n), .local_data_bus_out(dout), .local_data_bus_in(din), .mem_cmd(mcmd), .mem_ack(mack),
        .mem_rdata(mrd), .dreq_en(dreq_en), .dma_request(dreq), .io_wait_release(wrel));
    // ****************************************
    // bus tasks and verdict
    // ****************************************
    initial forever #2 ref_clk = ~ref_clk;
    task end_sim;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one classic cycle; master holds everything until ack is sampled
    task wb(input logic w, input logic [ADR_W-1:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        cyc <= 1'b1; we <= w; adr <= a; dat <= d;
        @(posedge ref_clk);
        while (ack !== 1'b1) @(posedge ref_clk);
        q = rdo;
        cyc <= 1'b0;
    endtask
    // pin picture of the last select 0 cycle, and total read strobe length
    always @(posedge ref_clk) begin
        cyc_cnt++;
        if (rd_n === 1'b0) rd_low++;
        if (sel_n[0] === 1'b0) pin_seen = {ben, bdir, moe, doe, la};
        if (cyc_cnt == 20000) begin
            mismatches++;
            end_sim();
        end
    end
    // ****************************************
    // tests
    // ****************************************
    initial begin
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        wb(1'b0, 25'h000_0004, 32'h0); chk(q, 32'hc000_0000);
        chk({idle, rdy}, 2'b10);
        wb(1'b1, 25'h000_0000, 32'h0000_c003);
        wb(1'b0, 25'h000_0000, 32'h0); chk(q, 32'h0000_c003);
        wb(1'b0, 25'h000_0010, 32'h0); chk(q, 32'h0);
        $display("registers done");
        wb(1'b1, 25'h100_0004, 32'h0000_a55a); chk({16'h0, p_u.last_wr}, 32'h0000_a55a);
        chk(pin_seen, 9'h0a1);
        wb(1'b0, 25'h100_0004, 32'h0); chk(q, 32'h0000_a55a);
        chk(pin_seen, 9'h001);
        chk(rd_low >= 60, 1'b1);
        $display("io cycles done");
        wb(1'b1, 25'h000_0004, 32'h0);
        @(posedge ref_clk);
        chk({idle, rdy}, 2'b11);
        wb(1'b1, 25'h000_000c, 32'h0000_0100);
        wb(1'b1, 25'h000_0008, 32'h0001_0002);
        wb(1'b1, 25'h000_0004, 32'h8000_0000);
        repeat (20) @(posedge ref_clk);
        chk({idle, mcmd.req}, 2'b00);
        wb(1'b0, 25'h000_0004, 32'h0); chk(q & 32'h8001_ffff, 32'h0001_0002);
        dreq_en <= 1'b1;
        while (idle !== 1'b1) @(posedge ref_clk);
        chk({16'h0, p_u.last_wr}, 32'h0000_bfed);
        wb(1'b0, 25'h000_0004, 32'h0); chk(q & 32'h8000_ffff, 32'h8000_0000);
        chk({idle, rdy}, 2'b11);
        $display("dma done");
        end_sim();
    end
endmodule
